// ---- rtl/hscp_port.sv ----
`timescale 1ns/1ns
// Functional notes
// - One or two command bytes, MSB first
// - Reply bytes shifted out MSB first
// - Command bits sampled on rising clock
// - Command executes at chip select rise
// - Serial clock may idle either polarity
// - Reply line released while deselected
module hscp_port (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        ce,
   input  wire logic        chip_select_n,
   input  wire logic        serial_clock,
   input  wire logic        command_data,
   output logic             reply_line_out,
   output logic             reply_line_oe_n,
   output logic             cmd_valid,
   output logic [7:0]       cmd_code,
   output logic [7:0]       cmd_arg,
   output logic             cmd_has_arg,
   input  wire logic [15:0] reply_word
);
   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [2:0] cs_sync;
   logic [2:0] sck_sync;
   logic [2:0] dat_sync;
   logic       cs_stable;
   logic       sck_stable;
   logic       dat_stable;
   logic       next_cs_stable;
   logic       next_sck_stable;
   logic       next_dat_stable;

   // A change counts once stages two and three agree
   always_comb begin
      next_cs_stable  = cs_stable;
      next_sck_stable = sck_stable;
      next_dat_stable = dat_stable;
      if (cs_sync[1] == cs_sync[2]) next_cs_stable = cs_sync[2];
      if (sck_sync[1] == sck_sync[2]) next_sck_stable = sck_sync[2];
      if (dat_sync[1] == dat_sync[2]) next_dat_stable = dat_sync[2];
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cs_sync    <= hscp_pkg::SYNC_RST;
         sck_sync   <= 3'h0;
         dat_sync   <= 3'h0;
         cs_stable  <= 1'b1;
         sck_stable <= 1'b0;
         dat_stable <= 1'b0;
      end else if (ce) begin
         cs_sync    <= {cs_sync[1:0], chip_select_n};
         sck_sync   <= {sck_sync[1:0], serial_clock};
         dat_sync   <= {dat_sync[1:0], command_data};
         cs_stable  <= next_cs_stable;
         sck_stable <= next_sck_stable;
         dat_stable <= next_dat_stable;
      end
   end

   // Edge events on filtered levels
   logic sck_rise;
   logic sck_fall;
   logic cs_fall;
   logic cs_rise;
   assign sck_rise = next_sck_stable & ~sck_stable;
   assign sck_fall = ~next_sck_stable & sck_stable;
   assign cs_fall  = ~next_cs_stable & cs_stable;
   assign cs_rise  = next_cs_stable & ~cs_stable;

   // ****************************************
   // Transaction engine
   // ****************************************
   hscp_pkg::hscp_state_t state;
   hscp_pkg::hscp_state_t next_state;
   logic [2:0]  bit_cnt;
   logic [2:0]  next_bit_cnt;
   logic [7:0]  shift_in;
   logic [7:0]  next_shift_in;
   logic [7:0]  code;
   logic [7:0]  next_code;
   logic [7:0]  arg;
   logic [7:0]  next_arg;
   logic        arg_done;
   logic        next_arg_done;
   logic [15:0] shift_out;
   logic [15:0] next_shift_out;
   logic        drive;
   logic        next_drive;
   logic        valid;
   logic        next_valid;
   logic        out_bit;
   logic        next_out_bit;
   logic        primed;
   logic        next_primed;

   always_comb begin
      next_state     = state;
      next_bit_cnt   = bit_cnt;
      next_shift_in  = shift_in;
      next_code      = code;
      next_arg       = arg;
      next_arg_done  = arg_done;
      next_shift_out = shift_out;
      next_drive     = drive;
      next_valid     = 1'b0;
      next_out_bit   = out_bit;
      next_primed    = primed;
      unique case (state)
         hscp_pkg::HSCP_IDLE: begin
            next_drive = 1'b0;
            if (cs_fall) begin
               next_state    = hscp_pkg::HSCP_CMD;
               next_bit_cnt  = hscp_pkg::BIT_RST;
               next_arg_done = 1'b0;
               next_code     = hscp_pkg::BYTE_RST;
               next_arg      = hscp_pkg::BYTE_RST;
               next_primed   = 1'b0;
            end
         end
         hscp_pkg::HSCP_CMD, hscp_pkg::HSCP_DATA: begin
            // Edges only matter relative to sampling; idle level free
            if (sck_rise) begin
               next_shift_in = {shift_in[6:0], dat_stable};
               next_bit_cnt  = bit_cnt + 3'h1;
               if (bit_cnt == hscp_pkg::BIT_LAST) begin
                  if (state == hscp_pkg::HSCP_CMD) begin
                     // Command byte picks count and direction
                     next_code  = {shift_in[6:0], dat_stable};
                     next_state = hscp_pkg::HSCP_DATA;
                     if (shift_in[hscp_pkg::CMD_RD_BIT - 1]) begin
                        next_shift_out = reply_word;
                        next_drive     = 1'b1;
                        next_primed    = 1'b1;
                     end
                  end else if (code[hscp_pkg::CMD_LEN_BIT]
                               && !code[hscp_pkg::CMD_RD_BIT]
                               && !arg_done) begin
                     next_arg      = {shift_in[6:0], dat_stable};
                     next_arg_done = 1'b1;
                  end
               end
            end
            // Reply bits change after the falling clock edge
            if (sck_fall && drive) begin
               if (primed) begin
                  next_out_bit   = shift_out[15];
                  next_shift_out = {shift_out[14:0], 1'b0};
                  next_primed    = 1'b0;
               end else begin
                  next_out_bit   = shift_out[15];
                  next_shift_out = {shift_out[14:0], 1'b0};
               end
            end
            if (cs_rise) begin
               next_state = hscp_pkg::HSCP_IDLE;
               next_drive = 1'b0;
               // Act only when the transaction closes
               next_valid = (state == hscp_pkg::HSCP_DATA);
            end
         end
         default: begin
            next_state = hscp_pkg::HSCP_IDLE;
            next_drive = 1'b0;
         end
      endcase
      if (next_cs_stable) next_drive = 1'b0;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state     <= hscp_pkg::HSCP_IDLE;
         bit_cnt   <= hscp_pkg::BIT_RST;
         shift_in  <= hscp_pkg::BYTE_RST;
         code      <= hscp_pkg::BYTE_RST;
         arg       <= hscp_pkg::BYTE_RST;
         arg_done  <= 1'b0;
         shift_out <= 16'h0000;
         drive     <= 1'b0;
         valid     <= 1'b0;
         out_bit   <= 1'b0;
         primed    <= 1'b0;
      end else if (ce) begin
         state     <= next_state;
         bit_cnt   <= next_bit_cnt;
         shift_in  <= next_shift_in;
         code      <= next_code;
         arg       <= next_arg;
         arg_done  <= next_arg_done;
         shift_out <= next_shift_out;
         drive     <= next_drive;
         valid     <= next_valid;
         out_bit   <= next_out_bit;
         primed    <= next_primed;
      end
   end

   // Outputs
   assign reply_line_out  = out_bit;
   assign reply_line_oe_n = ~drive;
   assign cmd_valid       = valid;
   assign cmd_code        = code;
   assign cmd_arg         = arg;
   assign cmd_has_arg     = arg_done;

   // ****************************************
   // Checks
   // ****************************************
   AST_RELEASE: assert property (@(posedge clk) disable iff (!rst_n)
      cs_stable |-> reply_line_oe_n)
      else $error("Reply line driven while deselected");
   AST_EXEC_AT_END: assert property (
      @(posedge clk) disable iff (!rst_n)
      cmd_valid |-> $past(cs_rise) && cs_stable)
      else $error("Command executed before chip select rise");
   AST_VALID_PULSE: assert property (
      @(posedge clk) disable iff (!rst_n)
      cmd_valid |=> !cmd_valid)
      else $error("Command strobe longer than one cycle");
   AST_SAMPLE_RISE: assert property (
      @(posedge clk) disable iff (!rst_n)
      (ce && !sck_rise && state != hscp_pkg::HSCP_IDLE) |=> $stable(bit_cnt))
      else $error("Bit counted without rising clock");
   AST_MSB_FIRST: assert property (@(posedge clk) disable iff (!rst_n)
      (ce && sck_rise && state == hscp_pkg::HSCP_CMD
       && bit_cnt == hscp_pkg::BIT_LAST) |=> cmd_code[0] == $past(dat_stable))
      else $error("Last command bit not in LSB");
   AST_REPLY_MSB: assert property (@(posedge clk) disable iff (!rst_n)
      (ce && sck_fall && drive && !next_cs_stable)
      |=> reply_line_out == $past(shift_out[15]))
      else $error("Reply bit not taken from MSB");
   AST_DRIVE_SEL: assert property (@(posedge clk) disable iff (!rst_n)
      !reply_line_oe_n |-> state == hscp_pkg::HSCP_DATA)
      else $error("Reply before command byte complete");
   AST_IDLE_QUIET: assert property (
      @(posedge clk) disable iff (!rst_n)
      (state == hscp_pkg::HSCP_IDLE) |-> reply_line_oe_n)
      else $error("Reply driven in idle");
   COV_EXEC: cover property (@(posedge clk) disable iff (!rst_n) cmd_valid);
   COV_ARG: cover property (@(posedge clk) disable iff (!rst_n)
      cmd_valid && cmd_has_arg);
   COV_READ: cover property (@(posedge clk) disable iff (!rst_n)
      !reply_line_oe_n ##1 reply_line_oe_n);
endmodule // hscp_port

// ---- rtl/hscp_pkg.sv ----
package hscp_pkg;
   // ****************************************
   // Command decoding
   // ****************************************
   // First byte bit 7 set and bit 6 clear: command carries a second byte
   localparam int        CMD_LEN_BIT  = 7;
   // First byte bit 6 set: command returns reply data
   localparam int        CMD_RD_BIT   = 6;
   // Reply byte count when reading
   localparam logic [1:0] RD_BYTES    = 2'h2;
   localparam logic [2:0] BIT_LAST    = 3'h7;
   localparam logic [2:0] BIT_RST     = 3'h0;
   localparam logic [7:0] BYTE_RST    = 8'h00;
   localparam logic [2:0] SYNC_RST    = 3'h7;

   // ****************************************
   // Reply line timing
   // ****************************************
   localparam int CLK_PERIOD_PS = 4000;
   localparam int HIZ_MAX_NS    = 1000;
   // Longest release time, rounded down
   localparam int HIZ_CYCLES = (HIZ_MAX_NS * 1000) / CLK_PERIOD_PS;

   // ****************************************
   // Port states
   // ****************************************
   typedef enum logic [2:0] {
      HSCP_IDLE = 3'b001,
      HSCP_CMD  = 3'b010,
      HSCP_DATA = 3'b100
   } hscp_state_t;
endpackage

// ---- test/hscp_host_model.sv ----
`timescale 1ns/1ns
module hscp_host_model (
   input  wire logic clk,
   output logic      chip_select_n,
   output logic      serial_clock,
   output logic      command_data,
   input  wire logic reply_bit
);
   // ****************************************
   // Host master driving the serial pins
   // ****************************************
   localparam int HALF = 20; // 80 ns half period of the serial clock
   initial begin
      chip_select_n = 1'b1;
      serial_clock  = 1'b0;
      command_data  = 1'b0;
   end
   // Select, shift bits MSB first, sample reply at each rise
   task automatic frame(input logic [7:0] code, input logic [7:0] arg,
                        input int nbits, input logic idle_hi,
                        output logic [15:0] rd);
      logic [15:0] tx;
      tx = {code, arg};
      rd = 16'h0000;
      @(negedge clk);
      serial_clock  = idle_hi;
      chip_select_n = 1'b0;
      repeat (30) @(negedge clk);
      for (int i = 0; i < nbits; i++) begin
         serial_clock = 1'b0;
         command_data = (i < 16) ? tx[15-i] : 1'b0;
         repeat (HALF) @(negedge clk);
         serial_clock = 1'b1;
         rd = {rd[14:0], reply_bit};
         repeat (HALF) @(negedge clk);
      end
      serial_clock = idle_hi;
      repeat (30) @(negedge clk);
   endtask
   // Deselect; data line left meaningless between frames
   task automatic close();
      @(negedge clk);
      chip_select_n = 1'b1;
      command_data  = ~command_data;
   endtask
endmodule // hscp_host_model

// ---- test/test_host_serial_command_port.sv ----
`timescale 1ns/1ns
module test_host_serial_command_port;
   // ****************************************
   // Bench signals and design under test
   // ****************************************
   typedef struct packed {
      logic [7:0]  code;
      logic [7:0]  arg;
      logic [7:0]  nbits;
      logic        idle_hi;
      logic [15:0] word;
      logic        has_arg;
   } hscp_row_t;
   logic        clk, rst_n, cs_n, sclk, cdata, r_out, r_oe_n, last_reply;
   logic        cmd_valid, cmd_has_arg, reply_wire;
   logic [7:0]  cmd_code, cmd_arg;
   logic [15:0] reply_word, rd;
   int          mismatches, checks_done, cycles, valid_cnt, n0;
   hscp_row_t   rows [5] = '{
      '{8'h93, 8'h5a, 8'h10, 1'b0, 16'h0000, 1'b1},
      '{8'h81, 8'h01, 8'h10, 1'b1, 16'h0000, 1'b1},
      '{8'h05, 8'hff, 8'h10, 1'b0, 16'h0000, 1'b0},
      '{8'h41, 8'h00, 8'h18, 1'b1, 16'ha5c3, 1'b0},
      '{8'hc2, 8'h00, 8'h18, 1'b0, 16'h3c96, 1'b0}};
   hscp_port uut (.clk(clk), .rst_n(rst_n), .ce(1'b1),
      .chip_select_n(cs_n), .serial_clock(sclk), .command_data(cdata),
      .reply_line_out(r_out), .reply_line_oe_n(r_oe_n),
      .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_arg(cmd_arg),
      .cmd_has_arg(cmd_has_arg), .reply_word(reply_word));
   hscp_host_model host (.clk(clk), .chip_select_n(cs_n),
      .serial_clock(sclk), .command_data(cdata), .reply_bit(reply_wire));
   // Released line shows inverse of its last driven value
   assign reply_wire = (r_oe_n === 1'b0) ? r_out : ~last_reply;
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Pulse counter, line history and timeout
   always @(posedge clk) begin
      cycles++;
      if (cmd_valid === 1'b1) valid_cnt++;
      // Remember only what the design itself drove
      if (!rst_n) last_reply <= 1'b0;
      else if (r_oe_n === 1'b0) last_reply <= r_out;
      if (cycles == 40000) begin
         mismatches++;
         end_of_test();
      end
   end
   task automatic check(input string name, input logic [15:0] exp,
                        input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Whole transaction with checks around the chip select rise
   task automatic run(input hscp_row_t r);
      reply_word = r.word;
      n0 = valid_cnt;
      host.frame(r.code, r.arg, int'(r.nbits), r.idle_hi, rd);
      check("early valid", 16'(n0), 16'(valid_cnt));
      host.close();
      repeat (20) @(negedge clk);
      check("valid pulses", 16'(n0 + 1), 16'(valid_cnt));
      check("code", {8'h00, r.code}, {8'h00, cmd_code});
      check("has arg", {15'h0, r.has_arg}, {15'h0, cmd_has_arg});
      check("arg", 16'(r.has_arg ? r.arg : 8'h00), 16'(cmd_arg));
      check("oe_n", 16'h0001, {15'h0, r_oe_n});
      if (r.code[6]) check("reply", r.word, rd);
      repeat (260) @(negedge clk);
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      rst_n = 1'b0;
      reply_word = 16'h0000;
      repeat (5) @(negedge clk);
      check("oe_n reset", 16'h0001, {15'h0, r_oe_n});
      check("code reset", 16'h0000, {8'h00, cmd_code});
      check("valid reset", 16'h0000, {15'h0, cmd_valid});
      rst_n = 1'b1;
      repeat (20) @(negedge clk);
      foreach (rows[i]) run(rows[i]);
      // Reset in mid-run clears the held command
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      check("code mid reset", 16'h0000, {8'h00, cmd_code});
      check("valid mid reset", 16'h0000, {15'h0, cmd_valid});
      rst_n = 1'b1;
      repeat (20) @(negedge clk);
      check("oe_n after reset", 16'h0001, {15'h0, r_oe_n});
      // Partial first byte gives no command
      n0 = valid_cnt;
      host.frame(8'h93, 8'h00, 4, 1'b1, rd);
      host.close();
      repeat (20) @(negedge clk);
      check("partial", 16'(n0), 16'(valid_cnt));
      check("oe_n partial", 16'h0001, {15'h0, r_oe_n});
      end_of_test();
   end
endmodule // test_host_serial_command_port
